// ---- logic/bmc_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bmc_params.svh"

module bmc_config_regs #(
  parameter logic [31:0] RAM_SIZE   = 32'h00020000,
  parameter logic [31:0] FLASH_SIZE = 32'h00080000
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic [31:0]        cpu_vaddr,
  input  wire logic               cpu_valid,
  input  wire logic               cpu_fetch,
  output bmc_pkg::bmc_xlat_t      cpu_xlat,
  input  wire logic [31:0]        dma_paddr,
  input  wire logic               dma_valid,
  output bmc_pkg::bmc_xlat_t      dma_xlat,
  input  wire logic [4:0]         unmapped_access,
  output logic [4:0]              bus_error,
  input  wire logic               ram_req,
  output logic                    ram_ack,
  output logic [4:0]              buserr_en,
  output logic                    ram_wait_state,
  output bmc_pkg::bmc_arb_t       arbitration_mode,
  output logic [31:0]             ram_kernel_program_base,
  output logic [31:0]             ram_user_data_base,
  output logic [31:0]             ram_user_program_base,
  output logic [31:0]             flash_user_program_base
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [31:0] config_r;
  logic [31:0] kpb_r;
  logic [31:0] udb_r;
  logic [31:0] upb_r;
  logic [31:0] fupb_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic hits(input logic [15:0] a,
                                input logic [15:0] base);
    // word access only: low two bits must be zero
    hits = (a[15:4] == base[15:4]) && (a[1:0] == 2'b00);
  endfunction : hits

  function automatic bmc_pkg::bmc_op_t op_of(input logic [15:0] a);
    if (a[3:2] == 2'(`BMC_ALIAS_CLR >> 2))
      op_of = bmc_pkg::BMC_OP_CLR;
    else if (a[3:2] == 2'(`BMC_ALIAS_SET >> 2))
      op_of = bmc_pkg::BMC_OP_SET;
    else if (a[3:2] == 2'(`BMC_ALIAS_INV >> 2))
      op_of = bmc_pkg::BMC_OP_INV;
    else
      op_of = bmc_pkg::BMC_OP_WRITE;
  endfunction : op_of

  // only implemented bits can ever change
  function automatic logic [31:0] apply(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input bmc_pkg::bmc_op_t op,
                                        input logic [31:0] mask);
    logic [31:0] v;
    v = old;
    case (op)
      bmc_pkg::BMC_OP_WRITE: v = wd;
      bmc_pkg::BMC_OP_CLR:   v = old & ~wd;
      bmc_pkg::BMC_OP_SET:   v = old | wd;
      bmc_pkg::BMC_OP_INV:   v = old ^ wd;
      default:               v = old;
    endcase
    apply = v & mask;
  endfunction : apply

  bmc_pkg::bmc_op_t wr_op;
  assign wr_op = op_of(reg_addr);

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      config_r <= `BMC_RST_CONFIG;
    else if (reg_wr && hits(reg_addr, `BMC_OFF_CONFIG))
      config_r <= apply(config_r, reg_wdata, wr_op,
                        `BMC_MASK_CONFIG);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      kpb_r <= `BMC_RST_BASE;
    else if (reg_wr && hits(reg_addr, `BMC_OFF_RAM_KPB))
      kpb_r <= apply(kpb_r, reg_wdata, wr_op,
                     `BMC_MASK_RAM_BASE);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      udb_r <= `BMC_RST_BASE;
    else if (reg_wr && hits(reg_addr, `BMC_OFF_RAM_UDB))
      udb_r <= apply(udb_r, reg_wdata, wr_op, `BMC_MASK_RAM_BASE);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      upb_r <= `BMC_RST_BASE;
    else if (reg_wr && hits(reg_addr, `BMC_OFF_RAM_UPB))
      upb_r <= apply(upb_r, reg_wdata, wr_op, `BMC_MASK_RAM_BASE);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      fupb_r <= `BMC_RST_BASE;
    else if (reg_wr && hits(reg_addr, `BMC_OFF_FLASH_UPB))
      fupb_r <= apply(fupb_r, reg_wdata, wr_op,
                      `BMC_MASK_FLASH_BASE);
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // aliases are write-only and read as zero; size words ignore writes
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (reg_addr[3:0] != 4'h0)
      rdata_nxt = 32'h00000000;
    else if (hits(reg_addr, `BMC_OFF_CONFIG))
      rdata_nxt = config_r;
    else if (hits(reg_addr, `BMC_OFF_RAM_KPB))
      rdata_nxt = kpb_r;
    else if (hits(reg_addr, `BMC_OFF_RAM_UDB))
      rdata_nxt = udb_r;
    else if (hits(reg_addr, `BMC_OFF_RAM_UPB))
      rdata_nxt = upb_r;
    else if (hits(reg_addr, `BMC_OFF_RAM_SIZE))
      rdata_nxt = RAM_SIZE;
    else if (hits(reg_addr, `BMC_OFF_FLASH_UPB))
      rdata_nxt = fupb_r;
    else if (hits(reg_addr, `BMC_OFF_FLASH_SIZE))
      rdata_nxt = FLASH_SIZE;
    else if (hits(reg_addr, `BMC_OFF_BOOT_SIZE))
      rdata_nxt = `BMC_BOOT_SIZE;
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clock)
  begin
    if (srst)
      rdata_r <= 32'h00000000;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 32'h00000000;
  end
  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  assign buserr_en      = config_r[`BMC_BUSERR_MSB:`BMC_BUSERR_LSB];
  assign ram_wait_state = config_r[`BMC_WAIT_BIT];
  assign ram_kernel_program_base = kpb_r;
  assign ram_user_data_base      = udb_r;
  assign ram_user_program_base   = upb_r;
  assign flash_user_program_base = fupb_r;

  // reserved codes are reported, not coerced; effect is undefined
  always_comb
  begin
    case (config_r[`BMC_ARB_MSB:`BMC_ARB_LSB])
      3'h0:    arbitration_mode = bmc_pkg::BMC_ARB_MODE0;
      3'h1:    arbitration_mode = bmc_pkg::BMC_ARB_MODE1;
      3'h2:    arbitration_mode = bmc_pkg::BMC_ARB_MODE2;
      default: arbitration_mode = bmc_pkg::BMC_ARB_RESERVED;
    endcase
  end

  // ---------------------------------------------------------------
  // bus error gating
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (srst)
      bus_error <= 5'h00;
    else
      bus_error <= unmapped_access & buserr_en;
  end

  // ---------------------------------------------------------------
  // data ram wait state
  // ---------------------------------------------------------------
  // a request during a pending extra cycle gets its own ack, one cycle after the first
  logic ram_wait_r;

  always_ff @(posedge clock)
  begin
    if (srst)
      ram_wait_r <= 1'b0;
    else
      ram_wait_r <= ram_req && ram_wait_state;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ram_ack <= 1'b0;
    else
      ram_ack <= ram_wait_state ? ram_wait_r : ram_req;
  end

  // ---------------------------------------------------------------
  // address classification
  // ---------------------------------------------------------------
  function automatic bmc_pkg::bmc_region_t region_of(
      input logic [31:0] p);
    if (p >= `BMC_PHYS_RAM && p < `BMC_PHYS_RAM + RAM_SIZE)
      region_of = bmc_pkg::BMC_RGN_RAM;
    else if (p >= `BMC_PHYS_FLASH && p < `BMC_PHYS_FLASH + FLASH_SIZE)
      region_of = bmc_pkg::BMC_RGN_FLASH;
    else if (p >= `BMC_PHYS_SFR && p < `BMC_PHYS_SFR_END)
      region_of = bmc_pkg::BMC_RGN_SFR;
    else if (p >= `BMC_PHYS_BOOT && p < `BMC_PHYS_BOOT_END)
      region_of = bmc_pkg::BMC_RGN_BOOT;
    else
      region_of = bmc_pkg::BMC_RGN_NONE;
  endfunction : region_of

  // a zero base leaves that partition empty
  function automatic bmc_pkg::bmc_part_t part_of(
      input logic [31:0] p, input bmc_pkg::bmc_region_t r);
    logic [31:0] off;
    off = p - `BMC_PHYS_RAM;
    part_of = bmc_pkg::BMC_PART_KDATA;
    if (r == bmc_pkg::BMC_RGN_RAM)
    begin
      if (upb_r != 32'h0 && off >= upb_r)
        part_of = bmc_pkg::BMC_PART_UPROG;
      else if (udb_r != 32'h0 && off >= udb_r)
        part_of = bmc_pkg::BMC_PART_UDATA;
      else if (kpb_r != 32'h0 && off >= kpb_r)
        part_of = bmc_pkg::BMC_PART_KPROG;
    end
    else if (r == bmc_pkg::BMC_RGN_FLASH)
    begin
      off = p - `BMC_PHYS_FLASH;
      if (fupb_r != 32'h0 && off >= fupb_r)
        part_of = bmc_pkg::BMC_PART_UPROG;
      else
        part_of = bmc_pkg::BMC_PART_KPROG;
    end
  endfunction : part_of

  function automatic logic exec_of(input bmc_pkg::bmc_region_t r,
                                   input bmc_pkg::bmc_part_t pt);
    if (r == bmc_pkg::BMC_RGN_RAM)
      exec_of = (pt == bmc_pkg::BMC_PART_KPROG) ||
                (pt == bmc_pkg::BMC_PART_UPROG);
    else
      exec_of = (r == bmc_pkg::BMC_RGN_FLASH) ||
                (r == bmc_pkg::BMC_RGN_BOOT);
  endfunction : exec_of

  // ---------------------------------------------------------------
  // processor translation
  // ---------------------------------------------------------------
  bmc_pkg::bmc_xlat_t cpu_nxt;
  logic [31:0]        cpu_phys;
  logic               cpu_cache;
  logic               cpu_user;

  always_comb
  begin
    cpu_phys  = cpu_vaddr;
    cpu_cache = 1'b0;
    cpu_user  = 1'b0;
    if (cpu_vaddr[31:29] == 3'b100)
    begin
      cpu_phys  = {3'b000, cpu_vaddr[28:0]};
      cpu_cache = 1'b1;
    end
    else if (cpu_vaddr[31:29] == 3'b101)
    begin
      cpu_phys  = {3'b000, cpu_vaddr[28:0]};
      cpu_cache = 1'b0;
    end
    else if (!cpu_vaddr[31])
    begin
      cpu_phys  = cpu_vaddr + `BMC_USER_OFFSET;
      cpu_cache = 1'b1;
      cpu_user  = 1'b1;
    end
  end

  always_comb
  begin
    cpu_nxt.phys      = cpu_phys;
    cpu_nxt.cacheable = cpu_cache;
    cpu_nxt.user      = cpu_user;
    cpu_nxt.region    = region_of(cpu_phys);
    cpu_nxt.part      = part_of(cpu_phys, cpu_nxt.region);
    cpu_nxt.exec_ok   = cpu_fetch ? exec_of(cpu_nxt.region,
                                            cpu_nxt.part) : 1'b1;
    cpu_nxt.valid     = cpu_valid;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      cpu_xlat <= '0;
    else
      cpu_xlat <= cpu_nxt;
  end

  // ---------------------------------------------------------------
  // physical masters
  // ---------------------------------------------------------------
  // no translation: the address is already physical
  bmc_pkg::bmc_xlat_t dma_nxt;

  always_comb
  begin
    dma_nxt.phys      = dma_paddr;
    dma_nxt.cacheable = 1'b0;
    dma_nxt.user      = 1'b0;
    dma_nxt.region    = region_of(dma_paddr);
    dma_nxt.part      = part_of(dma_paddr, dma_nxt.region);
    dma_nxt.exec_ok   = 1'b0;
    dma_nxt.valid     = dma_valid;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      dma_xlat <= '0;
    else
      dma_xlat <= dma_nxt;
  end

endmodule : bmc_config_regs
`default_nettype wire

// ---- logic/bmc_params.svh ----
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH
// register byte offsets
`define BMC_OFF_CONFIG      16'h2000
`define BMC_OFF_RAM_KPB     16'h2010
`define BMC_OFF_RAM_UDB     16'h2020
`define BMC_OFF_RAM_UPB     16'h2030
`define BMC_OFF_RAM_SIZE    16'h2040
`define BMC_OFF_FLASH_UPB   16'h2050
`define BMC_OFF_FLASH_SIZE  16'h2060
`define BMC_OFF_BOOT_SIZE   16'h2070
// alias offsets added to a base register
`define BMC_ALIAS_CLR       16'h0004
`define BMC_ALIAS_SET       16'h0008
`define BMC_ALIAS_INV       16'h000c
// field positions in the configuration register
`define BMC_BUSERR_LSB      16
`define BMC_BUSERR_MSB      20
`define BMC_WAIT_BIT        6
`define BMC_ARB_LSB         0
`define BMC_ARB_MSB         2
// reset values and implemented-bit masks
`define BMC_RST_CONFIG      32'h001f0041
`define BMC_RST_BASE        32'h00000000
`define BMC_MASK_CONFIG     32'h001f0047
`define BMC_MASK_RAM_BASE   32'h0000fc00
`define BMC_MASK_FLASH_BASE 32'h000fffff
`define BMC_BOOT_SIZE       32'h00003000
// physical memory layout of the unified space
`define BMC_PHYS_RAM        32'h00000000
`define BMC_PHYS_FLASH      32'h1d000000
`define BMC_PHYS_SFR        32'h1f800000
`define BMC_PHYS_SFR_END    32'h1fc00000
`define BMC_PHYS_BOOT       32'h1fc00000
`define BMC_PHYS_BOOT_END   32'h1fc03000
`define BMC_USER_OFFSET     32'h40000000
`endif

// ---- logic/bmc_pkg.sv ----
`default_nettype none
package bmc_pkg;
  typedef enum logic [1:0] {
    BMC_ARB_MODE0,
    BMC_ARB_MODE1,
    BMC_ARB_MODE2,
    BMC_ARB_RESERVED
  } bmc_arb_t;

  typedef enum logic [2:0] {
    BMC_RGN_NONE,
    BMC_RGN_RAM,
    BMC_RGN_FLASH,
    BMC_RGN_SFR,
    BMC_RGN_BOOT
  } bmc_region_t;

  typedef enum logic [1:0] {
    BMC_PART_KDATA,
    BMC_PART_KPROG,
    BMC_PART_UDATA,
    BMC_PART_UPROG
  } bmc_part_t;

  typedef enum logic [1:0] {
    BMC_OP_WRITE,
    BMC_OP_CLR,
    BMC_OP_SET,
    BMC_OP_INV
  } bmc_op_t;

  typedef struct packed {
    logic [31:0] phys;
    logic        cacheable;
    logic        user;
    bmc_region_t region;
    bmc_part_t   part;
    logic        exec_ok;
    logic        valid;
  } bmc_xlat_t;
endpackage : bmc_pkg
`default_nettype wire

// ---- verification/bmc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// register bank port checks
// ----------------------------------------
module bmc_checker (
  input wire logic               clock,
  input wire logic               srst,
  input wire logic [15:0]        reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic [31:0]        cpu_vaddr,
  input wire logic               cpu_valid,
  input wire bmc_pkg::bmc_xlat_t cpu_xlat,
  input wire logic [31:0]        dma_paddr,
  input wire logic               dma_valid,
  input wire bmc_pkg::bmc_xlat_t dma_xlat,
  input wire logic [4:0]         unmapped_access,
  input wire logic [4:0]         bus_error,
  input wire logic               ram_req,
  input wire logic               ram_ack,
  input wire logic [4:0]         buserr_en,
  input wire logic               ram_wait_state,
  input wire bmc_pkg::bmc_arb_t  arbitration_mode,
  input wire logic [31:0]        ram_kernel_program_base,
  input wire logic [31:0]        flash_user_program_base
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence s_cfg_wr;
    reg_wr && reg_addr == 16'h2000;
  endsequence
  sequence s_slow_ack;
    !ram_ack ##1 ram_ack;
  endsequence
  property p_rd_idle;
    !$past(srst) && !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("rdata not idle");
  property p_cfg;
    s_cfg_wr |=> buserr_en == $past(reg_wdata[20:16])
      && ram_wait_state == $past(reg_wdata[6]);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config fields");
  property p_arb;
    s_cfg_wr |=> arbitration_mode == (($past(reg_wdata[2:0]) > 3'h2) ?
      bmc_pkg::BMC_ARB_RESERVED :
      bmc_pkg::bmc_arb_t'($past(reg_wdata[1:0])));
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration decode");
  property p_kpb_set;
    reg_wr && reg_addr == 16'h2018 |=> ram_kernel_program_base ==
      (($past(ram_kernel_program_base) | $past(reg_wdata)) & 32'h0000fc00);
  endproperty
  a_kpb_set: assert property (p_kpb_set)
    else $error("set alias");
  property p_fl_clr;
    reg_wr && reg_addr == 16'h2054 |=> flash_user_program_base ==
      ($past(flash_user_program_base) & ~$past(reg_wdata));
  endproperty
  a_fl_clr: assert property (p_fl_clr)
    else $error("clear alias");
  property p_masks;
    ram_kernel_program_base[9:0] == 10'h0
      && flash_user_program_base[31:20] == 12'h0;
  endproperty
  a_masks: assert property (p_masks)
    else $error("base mask");
  property p_buserr;
    !srst |=> bus_error == $past(unmapped_access & buserr_en);
  endproperty
  a_buserr: assert property (p_buserr)
    else $error("bus error");
  property p_ack_fast;
    ram_req && !ram_wait_state |=> ram_ack;
  endproperty
  a_ack_fast: assert property (p_ack_fast)
    else $error("fast ack");
  property p_ack_slow;
    ram_req && ram_wait_state |=> s_slow_ack;
  endproperty
  a_ack_slow: assert property (p_ack_slow)
    else $error("slow ack");
  property p_boot;
    reg_rd && reg_addr == 16'h2070 |=> reg_rdata == 32'h00003000;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot size");
  property p_kseg;
    !srst && cpu_valid && cpu_vaddr[31:30] == 2'h2 |=>
      cpu_xlat.phys == {3'h0, $past(cpu_vaddr[28:0])}
      && cpu_xlat.cacheable == !$past(cpu_vaddr[29]);
  endproperty
  a_kseg: assert property (p_kseg)
    else $error("kernel xlat");
  // a reset edge zeroes the outputs, so it starts no attempt
  property p_dma;
    !srst && dma_valid |=>
      dma_xlat.phys == $past(dma_paddr) && !dma_xlat.cacheable;
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma xlat");
endmodule : bmc_checker

bind bmc_config_regs bmc_checker i_chk (.clock, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_vaddr, .cpu_valid,
  .cpu_xlat, .dma_paddr, .dma_valid, .dma_xlat, .unmapped_access,
  .bus_error, .ram_req, .ram_ack, .buserr_en, .ram_wait_state,
  .arbitration_mode, .ram_kernel_program_base, .flash_user_program_base);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] RSTV [8] = '{32'h001f0041, 32'h0, 32'h0, 32'h0,
    32'h00010000, 32'h0, 32'h00040000, 32'h00003000};
  localparam logic [31:0] VA [4] = '{32'h80000100, 32'h80000800,
    32'ha0000100, 32'h00001000};
  localparam logic [31:0] PA [4] = '{32'h00000100, 32'h00000800,
    32'h00000100, 32'h40001000};
  localparam int RO [3] = '{4, 6, 7};
  logic clock, srst, reg_wr, reg_rd, cpu_valid, cpu_fetch, dma_valid;
  logic ram_req, ram_ack, ram_wait_state;
  logic [15:0] reg_addr, a;
  logic [31:0] reg_wdata, reg_rdata, cpu_vaddr, dma_paddr, m, q;
  logic [31:0] kpb, udb, upb, fupb;
  logic [4:0] unmapped_access, bus_error, buserr_en;
  bmc_pkg::bmc_xlat_t cpu_xlat, dma_xlat;
  bmc_pkg::bmc_arb_t arbitration_mode;
  int miscompares = 0;
  int n_compared = 0;

  bmc_config_regs #(.RAM_SIZE(RSTV[4]), .FLASH_SIZE(RSTV[6])) i_dut (
    .clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_vaddr, .cpu_valid, .cpu_fetch, .cpu_xlat, .dma_paddr, .dma_valid,
    .dma_xlat, .unmapped_access, .bus_error, .ram_req, .ram_ack,
    .buserr_en, .ram_wait_state, .arbitration_mode,
    .ram_kernel_program_base(kpb), .ram_user_data_base(udb),
    .ram_user_program_base(upb), .flash_user_program_base(fupb));

  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] ad, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {srst, reg_wr, reg_rd, ram_req, cpu_valid, cpu_fetch, dma_valid} = 7'h40;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    cpu_vaddr = 32'h0;
    dma_paddr = 32'h0;
    unmapped_access = 5'h0;
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    for (int i = 0; i < 8; i++)
      rd(16'h2000 + 16'(i * 16), RSTV[i]);
    chk({30'h0, arbitration_mode}, 32'h1);
    chk({27'h0, buserr_en}, 32'h1f);
    $display("test reset values done");
    wr(16'h2000, 32'hffffffff);
    rd(16'h2000, 32'h001f0047);
    for (int c = 0; c < 8; c++)
    begin
      wr(16'h2000, 32'(c));
      #1 chk({30'h0, arbitration_mode}, c < 3 ? 32'(c) : 32'h3);
      rd(16'h2000, 32'(c));
    end
    wr(16'h2000, 32'h00000041);
    wr(16'h2008, 32'h00100002);
    rd(16'h2000, 32'h00100043);
    wr(16'h2004, 32'h00000040);
    rd(16'h2000, 32'h00100003);
    wr(16'h200c, 32'h001f0007);
    rd(16'h2000, 32'h000f0004);
    rd(16'h2008, 32'h0);
    $display("test config done");
    for (int i = 0; i < 4; i++)
    begin
      a = i < 3 ? 16'h2010 + 16'(i * 16) : 16'h2050;
      m = i < 3 ? 32'h0000fc00 : 32'h000fffff;
      wr(a, 32'hffffffff);
      rd(a, m);
      wr(a + 16'h4, 32'h0000f000);
      rd(a, m & ~32'h0000f000);
      wr(a + 16'hc, 32'hffffffff);
      rd(a, m & 32'h0000f000);
      wr(a + 16'h8, 32'h00000401);
      rd(a, m & 32'h0000f401);
      q = i == 0 ? kpb : i == 1 ? udb : i == 2 ? upb : fupb;
      chk(q, m & 32'h0000f401);
      wr(a, 32'h0);
    end
    $display("test bases done");
    for (int i = 0; i < 3; i++)
    begin
      a = 16'h2000 + 16'(RO[i] * 16);
      wr(a, 32'hffffffff);
      wr(a + 16'h8, 32'hffffffff);
      rd(a, RSTV[RO[i]]);
    end
    wr(16'h2002, 32'hffffffff);
    rd(16'h2000, 32'h000f0004);
    rd(16'h2080, 32'h0);
    $display("test read-only done");
    wr(16'h2000, 32'h00150000);
    @(posedge clock);
    unmapped_access <= 5'h1f;
    @(posedge clock);
    unmapped_access <= 5'h0;
    #1 chk({27'h0, bus_error}, 32'h15);
    @(posedge clock);
    #1 chk({27'h0, bus_error}, 32'h0);
    for (int w = 0; w < 2; w++)
    begin
      wr(16'h2000, w != 0 ? 32'h00000040 : 32'h0);
      @(posedge clock);
      ram_req <= 1'h1;
      chk({31'h0, ram_wait_state}, 32'(w));
      @(posedge clock);
      ram_req <= 1'h0;
      if (w != 0)
      begin
        #1 chk({31'h0, ram_ack}, 32'h0);
        @(posedge clock);
      end
      #1 chk({31'h0, ram_ack}, 32'h1);
    end
    $display("test bus error and wait done");
    wr(16'h2010, 32'h00000400);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      cpu_vaddr <= VA[i];
      dma_paddr <= VA[i] & 32'h1fffffff;
      // last access is a data access, so execute permission is not asked
      {cpu_valid, cpu_fetch, dma_valid} <= i < 3 ? 3'h7 : 3'h5;
      @(posedge clock);
      #1 chk(cpu_xlat.phys, PA[i]);
      chk({31'h0, cpu_xlat.cacheable}, i == 2 ? 32'h0 : 32'h1);
      chk(dma_xlat.phys, VA[i] & 32'h1fffffff);
      chk(32'(dma_xlat.region), 32'h1);
      chk({30'h0, dma_xlat.exec_ok, dma_xlat.user}, 32'h0);
      chk({30'h0, cpu_xlat.valid, dma_xlat.valid}, 32'h3);
      chk(32'(cpu_xlat.region), i < 3 ? 32'h1 : 32'h0);
      chk({31'h0, cpu_xlat.user}, i == 3 ? 32'h1 : 32'h0);
      if (i < 2)
      begin
        chk({30'h0, cpu_xlat.part}, 32'(i));
        chk({31'h0, cpu_xlat.exec_ok}, 32'(i));
      end
      else if (i == 3)
        chk({31'h0, cpu_xlat.exec_ok}, 32'h1);
    end
    $display("test translation done");
    @(posedge clock);
    srst <= 1'h1;
    @(posedge clock);
    srst <= 1'h0;
    rd(16'h2000, 32'h001f0041);
    rd(16'h2010, 32'h0);
    $display("test second reset done");
    summarize();
  end

  initial
  begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
